// file: include/osreg_pkg.sv
// Constants, command codes and status layout of the offset and status register block
// Operation
// - Temperature offset bits weigh 10.9375 down to 0.1709
// - Temperature offset spans 0.1709 to 21.7041 degrees
// - Sign one adds offset, zero subtracts it
// - Command A0 04 reads back offsets plus CRC
// - Command F3 2D reads status plus CRC
// - Clear command returns latched status flags cleared
// - Bit 15 shows any active alert, resets one
// - Bit 13 shows heater enabled, resets zero
// - Bits 11, 10 show tracking alerts live
// - Bits 9, 8 flag humidity threshold alerts
// - Bits 7, 6 flag temperature threshold alerts
// - Bit 4 flags any reset until cleared
// - Bit 0 reports CRC result of last write
// - Status reads return flags current at read
// - Offsets held as one sixteen bit word
// - Humidity correction uses raw, not adjusted, temperature
package osreg_pkg;
	// Bus address, arbitrary choice for this build
	localparam logic [6:0] DEV_ADDR = 7'h44;
	// Command codes
	localparam logic [15:0] CMD_OFFSET = 16'hA004;
	localparam logic [15:0] CMD_STATUS = 16'hF32D;
	localparam logic [15:0] CMD_CLEAR = 16'h3041;
	// Byte counts of write transfers
	localparam logic [2:0] WCNT_CMD = 3'h2;
	localparam logic [2:0] WCNT_OFS = 3'h5;
	// CRC-8 polynomial and seed
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	// Reset values
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic OVERALL_RESET = 1'b1;
	localparam logic RSTDET_RESET = 1'b1;
	// Offset word layout: humidity byte high, temperature byte low
	localparam int HUM_SIGN_BIT = 15;
	localparam int TEMP_SIGN_BIT = 7;
	// Magnitude shift into result code (temperature bits 12..6, humidity 13..7)
	localparam int TEMP_MAG_SHIFT = 6;
	localparam int HUM_MAG_SHIFT = 7;
	// Status bit positions
	localparam int ST_OVERALL = 15;
	localparam int ST_HEATER = 13;
	localparam int ST_RH_TRACK = 11;
	localparam int ST_T_TRACK = 10;
	localparam int ST_RH_HIGH = 9;
	localparam int ST_RH_LOW = 8;
	localparam int ST_T_HIGH = 7;
	localparam int ST_T_LOW = 6;
	localparam int ST_RSTDET = 4;
	localparam int ST_CRCFAIL = 0;
	// Bus engine states, gray along address, receive, transmit path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b011,
		ST_RX = 3'b010,
		ST_RX_ACK = 3'b110,
		ST_TX = 3'b111,
		ST_TX_ACK = 3'b101,
		ST_WAIT = 3'b100
	} osreg_state_t;
endpackage

// file: hw/osreg_top.sv
// Bus slave, offset word, status flags and offset arithmetic
`timescale 1ns/10ps
module osreg_top (
	input wire logic ref_clk_in, // System clock, 25 MHz
	input wire logic reset_in, // Asynchronous reset, active high
	input wire logic scl_in, // Bus clock pin
	input wire logic sda_in, // Bus data pin level
	output logic sda_out, // Bus data drive value, always low
	output logic sda_oe_out, // Bus data drive enable
	input wire logic heater_on_in, // Heater enabled level
	input wire logic rh_track_alert_in, // Humidity tracking alert level
	input wire logic t_track_alert_in, // Temperature tracking alert level
	input wire logic rh_high_alert_in, // Humidity high alert event
	input wire logic rh_low_alert_in, // Humidity low alert event
	input wire logic t_high_alert_in, // Temperature high alert event
	input wire logic t_low_alert_in, // Temperature low alert event
	input wire logic soft_reset_in, // Soft reset command event
	input wire logic supply_fail_in, // Supply failure event
	input wire logic meas_valid_in, // Raw results valid strobe
	input wire logic [15:0] raw_temp_in, // Raw temperature code
	input wire logic [15:0] raw_rh_in, // Raw humidity code
	output logic [15:0] temp_adj_out, // Offset-corrected temperature
	output logic [15:0] rh_adj_out, // Offset-corrected humidity
	output logic result_valid_out, // Corrected results valid strobe
	output logic [15:0] offset_word_out // Current offset word
);
	// One CRC step over a byte
	function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ osreg_pkg::CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// CRC over a two-byte word, high byte first
	function automatic logic [7:0] crc8_word(input logic [15:0] w);
		return crc8_byte(crc8_byte(osreg_pkg::CRC_INIT, w[15:8]), w[7:0]);
	endfunction

	// Add or subtract a scaled magnitude, saturating at the code limits
	function automatic logic [15:0] apply_ofs(input logic [15:0] raw, input logic add,
			input logic [15:0] ofs);
		logic [16:0] s;
		s = add ? ({1'b0, raw} + {1'b0, ofs}) : ({1'b0, raw} - {1'b0, ofs});
		if (s[16]) begin
			return add ? 16'hFFFF : 16'h0000;
		end
		return s[15:0];
	endfunction

	logic scl_m_ff, scl_s_ff, scl_d_ff;
	logic sda_m_ff, sda_s_ff, sda_d_ff;
	osreg_pkg::osreg_state_t state_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [3:0] bit_cnt_ff;
	logic [1:0] rd_idx_ff;
	logic rw_ff;
	logic sda_oe_ff;
	logic [2:0] wcnt_ff;
	logic [15:0] cmd_ff;
	logic [23:0] wdata_ff;
	logic [15:0] rd_word_ff;
	logic [15:0] offset_ff;
	logic overall_ff, heater_ff, rh_track_ff, t_track_ff;
	logic rh_high_ff, rh_low_ff, t_high_ff, t_low_ff, rstdet_ff, crcfail_ff;
	logic [15:0] temp_adj_ff, rh_adj_ff;
	logic valid_ff;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic do_ofs_write, do_clear, any_alert;
	logic [15:0] status_word;
	logic [7:0] rd_crc;

	// Two-stage pin synchronisers plus a delay stage for edge finding
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_m_ff <= scl_in;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= sda_in;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	// Bus events; start and stop only while the clock stays high
	assign scl_rise = scl_s_ff & ~scl_d_ff;
	assign scl_fall = ~scl_s_ff & scl_d_ff;
	assign bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
	assign bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

	// Write transfers act only at stop, so an aborted write changes nothing
	assign do_ofs_write = bus_stop && cmd_ff == osreg_pkg::CMD_OFFSET
		&& wcnt_ff == osreg_pkg::WCNT_OFS;
	assign do_clear = bus_stop && cmd_ff == osreg_pkg::CMD_CLEAR
		&& wcnt_ff == osreg_pkg::WCNT_CMD;

	// Live tracking and latched threshold alerts feed the summary bit together with reset state
	assign any_alert = rh_track_ff | t_track_ff | rh_high_ff | rh_low_ff | t_high_ff | t_low_ff;

	// Checksum of the read word, held in a net so its top bit can be picked
	assign rd_crc = crc8_word(rd_word_ff);

	// Live status assembly; unlisted bits stay zero
	always_comb begin
		status_word = 16'h0000;
		status_word[osreg_pkg::ST_OVERALL] = overall_ff | any_alert;
		status_word[osreg_pkg::ST_HEATER] = heater_ff;
		status_word[osreg_pkg::ST_RH_TRACK] = rh_track_ff;
		status_word[osreg_pkg::ST_T_TRACK] = t_track_ff;
		status_word[osreg_pkg::ST_RH_HIGH] = rh_high_ff;
		status_word[osreg_pkg::ST_RH_LOW] = rh_low_ff;
		status_word[osreg_pkg::ST_T_HIGH] = t_high_ff;
		status_word[osreg_pkg::ST_T_LOW] = t_low_ff;
		status_word[osreg_pkg::ST_RSTDET] = rstdet_ff;
		status_word[osreg_pkg::ST_CRCFAIL] = crcfail_ff;
	end

	// Byte engine: address match, receive with ack, transmit with master ack
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= osreg_pkg::ST_IDLE;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			bit_cnt_ff <= 4'h0;
			rd_idx_ff <= 2'h0;
			rw_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (bus_start) begin
			state_ff <= osreg_pkg::ST_ADDR;
			bit_cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else if (bus_stop) begin
			state_ff <= osreg_pkg::ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				osreg_pkg::ST_ADDR, osreg_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_ff <= {shift_ff[6:0], sda_s_ff};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall && bit_cnt_ff == 4'h8) begin
						if (state_ff == osreg_pkg::ST_RX) begin
							state_ff <= osreg_pkg::ST_RX_ACK;
							sda_oe_ff <= 1'b1;
						end else if (shift_ff[7:1] == osreg_pkg::DEV_ADDR) begin
							state_ff <= osreg_pkg::ST_ADDR_ACK;
							rw_ff <= shift_ff[0];
							sda_oe_ff <= 1'b1;
						end else begin
							state_ff <= osreg_pkg::ST_WAIT;
						end
					end
				end
				osreg_pkg::ST_ADDR_ACK: begin
					if (scl_fall && rw_ff) begin
						// First read byte goes out right after the address ack
						state_ff <= osreg_pkg::ST_TX;
						tx_ff <= rd_word_ff[15:8];
						sda_oe_ff <= ~rd_word_ff[15];
						bit_cnt_ff <= 4'h1;
						rd_idx_ff <= 2'h1;
					end else if (scl_fall) begin
						state_ff <= osreg_pkg::ST_RX;
						sda_oe_ff <= 1'b0;
						bit_cnt_ff <= 4'h0;
					end
				end
				osreg_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						state_ff <= osreg_pkg::ST_RX;
						sda_oe_ff <= 1'b0;
						bit_cnt_ff <= 4'h0;
					end
				end
				osreg_pkg::ST_TX: begin
					if (scl_fall && bit_cnt_ff == 4'h8) begin
						state_ff <= osreg_pkg::ST_TX_ACK;
						sda_oe_ff <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_ff <= ~tx_ff[3'(4'h7 - bit_cnt_ff)];
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
				end
				osreg_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						shift_ff[0] <= sda_s_ff;
					end else if (scl_fall && shift_ff[0]) begin
						// Master nack ends the read; wait for stop
						state_ff <= osreg_pkg::ST_WAIT;
					end else if (scl_fall) begin
						state_ff <= osreg_pkg::ST_TX;
						bit_cnt_ff <= 4'h1;
						rd_idx_ff <= rd_idx_ff + 2'h1;
						unique case (rd_idx_ff)
							2'h1: begin
								tx_ff <= rd_word_ff[7:0];
								sda_oe_ff <= ~rd_word_ff[7];
							end
							2'h2: begin
								tx_ff <= rd_crc;
								sda_oe_ff <= ~rd_crc[7];
							end
							default: begin
								// Two bytes past the CRC byte return all ones, then the low byte comes again
								tx_ff <= 8'hFF;
								sda_oe_ff <= 1'b0;
							end
						endcase
					end
				end
				osreg_pkg::ST_IDLE, osreg_pkg::ST_WAIT: begin
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// Received bytes: two command bytes, then up to three data bytes
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wcnt_ff <= 3'h0;
			cmd_ff <= 16'h0000;
			wdata_ff <= 24'h00_0000;
		end else if (bus_start) begin
			wcnt_ff <= 3'h0;
		end else if (state_ff == osreg_pkg::ST_RX && scl_fall && bit_cnt_ff == 4'h8) begin
			if (wcnt_ff < osreg_pkg::WCNT_CMD) begin
				cmd_ff <= {cmd_ff[7:0], shift_ff};
			end else if (wcnt_ff < osreg_pkg::WCNT_OFS) begin
				wdata_ff <= {wdata_ff[15:0], shift_ff};
			end
			if (wcnt_ff < osreg_pkg::WCNT_OFS) begin
				wcnt_ff <= wcnt_ff + 3'h1;
			end
		end
	end

	// Read word snapshot when the read address is accepted
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_word_ff <= 16'h0000;
		end else if (state_ff == osreg_pkg::ST_ADDR && scl_fall && bit_cnt_ff == 4'h8
				&& shift_ff[7:1] == osreg_pkg::DEV_ADDR && shift_ff[0]) begin
			if (cmd_ff == osreg_pkg::CMD_OFFSET) begin
				rd_word_ff <= offset_ff;
			end else begin
				rd_word_ff <= status_word;
			end
		end
	end

	// Offset word, stored only when its CRC checks
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			offset_ff <= osreg_pkg::OFFSET_RESET;
		end else if (do_ofs_write && crc8_word(wdata_ff[23:8]) == wdata_ff[7:0]) begin
			offset_ff <= wdata_ff[23:8];
		end
	end

	// Live levels sampled each clock so reads see current state
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			heater_ff <= 1'b0;
			rh_track_ff <= 1'b0;
			t_track_ff <= 1'b0;
		end else begin
			heater_ff <= heater_on_in;
			rh_track_ff <= rh_track_alert_in;
			t_track_ff <= t_track_alert_in;
		end
	end

	// Sticky flags; a new event in the clear cycle wins over the clear
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			overall_ff <= osreg_pkg::OVERALL_RESET;
			rh_high_ff <= 1'b0;
			rh_low_ff <= 1'b0;
			t_high_ff <= 1'b0;
			t_low_ff <= 1'b0;
			rstdet_ff <= osreg_pkg::RSTDET_RESET;
		end else begin
			overall_ff <= overall_ff & ~do_clear;
			rh_high_ff <= rh_high_alert_in | (rh_high_ff & ~do_clear);
			rh_low_ff <= rh_low_alert_in | (rh_low_ff & ~do_clear);
			t_high_ff <= t_high_alert_in | (t_high_ff & ~do_clear);
			t_low_ff <= t_low_alert_in | (t_low_ff & ~do_clear);
			rstdet_ff <= soft_reset_in | supply_fail_in | (rstdet_ff & ~do_clear);
		end
	end

	// Checksum result of the most recent offset write
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			crcfail_ff <= 1'b0;
		end else if (do_ofs_write) begin
			crcfail_ff <= crc8_word(wdata_ff[23:8]) != wdata_ff[7:0];
		end else if (do_clear) begin
			crcfail_ff <= 1'b0;
		end
	end

	// Corrected results; humidity path never sees the adjusted temperature
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			temp_adj_ff <= 16'h0000;
			rh_adj_ff <= 16'h0000;
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= meas_valid_in;
			if (meas_valid_in) begin
				temp_adj_ff <= apply_ofs(raw_temp_in, offset_ff[osreg_pkg::TEMP_SIGN_BIT],
					{3'h0, offset_ff[6:0], 6'h00});
				rh_adj_ff <= apply_ofs(raw_rh_in, offset_ff[osreg_pkg::HUM_SIGN_BIT],
					{2'h0, offset_ff[14:8], 7'h00});
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = sda_oe_ff;
	assign temp_adj_out = temp_adj_ff;
	assign rh_adj_out = rh_adj_ff;
	assign result_valid_out = valid_ff;
	assign offset_word_out = offset_ff;
endmodule

// file: tb/osreg_properties.sv
// Port-level checks of the offset and status register block
`timescale 1ns/10ps
module osreg_properties (
	input wire logic ref_clk_in, // System clock
	input wire logic reset_in, // Async reset
	input wire logic scl_in, // Bus clock pin
	input wire logic sda_in, // Bus data level
	input wire logic sda_out, // Drive value
	input wire logic sda_oe_out, // Drive enable
	input wire logic meas_valid_in, // Raw valid
	input wire logic [15:0] raw_temp_in, // Raw temperature
	input wire logic [15:0] raw_rh_in, // Raw humidity
	input wire logic [15:0] temp_adj_out, // Corrected temperature
	input wire logic [15:0] rh_adj_out, // Corrected humidity
	input wire logic result_valid_out, // Corrected valid
	input wire logic [15:0] offset_word_out // Offset word
);
	logic sda_q_ff;
	logic [3:0] stop_age_ff;
	logic [16:0] t_add, t_sub, h_add;
	// Bit 16 flags overflow or borrow, so saturation is told apart
	assign t_add = {1'b0, raw_temp_in} + {4'h0, offset_word_out[6:0], 6'h00};
	assign t_sub = {1'b0, raw_temp_in} - {4'h0, offset_word_out[6:0], 6'h00};
	assign h_add = {1'b0, raw_rh_in} + {3'h0, offset_word_out[14:8], 7'h00};
	// Delayed data pin for stop detection
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) sda_q_ff <= 1'b1;
		else sda_q_ff <= sda_in;
	end
	// Cycles since the last stop seen on the pins, saturating
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) stop_age_ff <= 4'hF;
		else if (scl_in && sda_in && !sda_q_ff) stop_age_ff <= 4'h0;
		else if (stop_age_ff != 4'hF) stop_age_ff <= stop_age_ff + 4'h1;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_meas;
		meas_valid_in;
	endsequence
	sequence s_ofs_moved;
		!$stable(offset_word_out);
	endsequence
	property p_valid; s_meas |=> result_valid_out; endproperty
	property p_quiet;
		!meas_valid_in |=> !result_valid_out && $stable(temp_adj_out) && $stable(rh_adj_out);
	endproperty
	property p_t_add;
		s_meas and offset_word_out[7] && !t_add[16] |=> temp_adj_out == $past(t_add[15:0]);
	endproperty
	property p_t_sub;
		s_meas and !offset_word_out[7] && !t_sub[16] |=> temp_adj_out == $past(t_sub[15:0]);
	endproperty
	property p_t_sat;
		s_meas and (offset_word_out[7] ? t_add[16] : t_sub[16])
			|=> temp_adj_out == {16{$past(offset_word_out[7])}};
	endproperty
	property p_h_add;
		s_meas and offset_word_out[15] && !h_add[16] |=> rh_adj_out == $past(h_add[15:0]);
	endproperty
	property p_drive; sda_oe_out |-> !sda_out; endproperty
	property p_ofs_stop; s_ofs_moved |-> stop_age_ff < 4'hC; endproperty
	property p_rst; $fell(reset_in) |-> offset_word_out == 16'h0000 && !sda_oe_out; endproperty
	// Line must be let go soon after a stop and stay free until the stop age count saturates
	property p_idle;
		stop_age_ff >= 4'h3 && stop_age_ff != 4'hF |-> !sda_oe_out;
	endproperty
	a_valid: assert property (p_valid) else $error("result valid missing");
	a_quiet: assert property (p_quiet) else $error("results moved without valid");
	a_t_add: assert property (p_t_add) else $error("temperature add wrong");
	a_t_sub: assert property (p_t_sub) else $error("temperature subtract wrong");
	a_t_sat: assert property (p_t_sat) else $error("temperature saturation wrong");
	a_h_add: assert property (p_h_add) else $error("humidity add wrong");
	a_drive: assert property (p_drive) else $error("data driven high");
	a_ofs_stop: assert property (p_ofs_stop) else $error("offset moved off stop");
	a_rst: assert property (p_rst) else $error("reset values wrong");
	a_idle: assert property (p_idle) else $error("data driven after stop");
endmodule

// file: tb/osreg_i2c_ctl.sv
// Bus controller model: clock and open-drain data toward the block
`timescale 1ns/10ps
module osreg_i2c_ctl (
	input wire logic clk_in, // Bench clock, timing base
	input wire logic sda_in, // Resolved data line
	output logic scl_out, // Bus clock, stands high between frames
	output logic sda_oe_out // High pulls data low
);
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// Four bench clocks a half bit, 320 ns a bit
	task automatic half();
		repeat (4) @(negedge clk_in);
	endtask
	// Start or repeated start: data falls while clock high
	task automatic start();
		sda_oe_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_oe_out = 1'b1;
		half();
		scl_out = 1'b0;
	endtask
	// Stop: data rises while clock high, then idle
	task automatic stop();
		sda_oe_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_oe_out = 1'b0;
		half();
	endtask
	// Byte plus acknowledge, MSB first; a one releases the line
	task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
		output logic ack_rx);
		logic [8:0] sh;
		sh = {tx, ack_tx};
		for (int i = 8; i >= 0; i--) begin
			sda_oe_out = !sh[i];
			half();
			scl_out = 1'b1;
			half();
			sh[i] = sda_in;
			scl_out = 1'b0;
		end
		rx = sh[8:1];
		ack_rx = sh[0];
	endtask
endmodule

// file: tb/tb_offset_and_status_regs.sv
// Self-checking bench for the offset and status register block
`timescale 1ns/10ps
module tb_offset_and_status_regs;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic heater_on_in = 1'b0;
	logic [1:0] track = 2'h0;
	logic [5:0] ev = 6'h00;
	logic meas_valid_in = 1'b0;
	logic [15:0] raw_temp_in = 16'h0000;
	logic [15:0] raw_rh_in = 16'h0000;
	logic scl, ctl_oe, dut_oe, sda_drv, res_valid, ak;
	logic [15:0] temp_adj, rh_adj, ofs_word, w;
	logic [7:0] rx, c;
	wire sda;
	int err_total = 0;
	int checks_done = 0;
	// Pull-up wins unless someone pulls low
	assign sda = !(ctl_oe || (dut_oe && !sda_drv));
	always #20 ref_clk_in = !ref_clk_in;
	osreg_top dut (.ref_clk_in, .reset_in, .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
		.sda_oe_out(dut_oe), .heater_on_in, .rh_track_alert_in(track[1]),
		.t_track_alert_in(track[0]), .rh_high_alert_in(ev[5]), .rh_low_alert_in(ev[4]),
		.t_high_alert_in(ev[3]), .t_low_alert_in(ev[2]), .soft_reset_in(ev[1]),
		.supply_fail_in(ev[0]), .meas_valid_in, .raw_temp_in, .raw_rh_in,
		.temp_adj_out(temp_adj), .rh_adj_out(rh_adj), .result_valid_out(res_valid),
		.offset_word_out(ofs_word));
	osreg_i2c_ctl ctl (.clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(ctl_oe));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bench's own CRC-8 over a word, high byte first
	function automatic logic [7:0] crc8(input logic [15:0] v);
		logic [7:0] r;
		r = osreg_pkg::CRC_INIT;
		for (int i = 15; i >= 0; i--)
			r = {r[6:0], 1'b0} ^ ((r[7] ^ v[i]) ? osreg_pkg::CRC_POLY : 8'h00);
		return r;
	endfunction
	// Start, address with write, then command or data bytes
	task automatic hdr(input logic [6:0] adr, input logic [7:0] q[$]);
		ctl.start();
		ctl.xfer({adr, 1'b0}, 1'b1, rx, ak);
		check({15'h0000, ak}, {15'h0000, adr != osreg_pkg::DEV_ADDR});
		foreach (q[i]) begin
			ctl.xfer(q[i], 1'b1, rx, ak);
			if (adr == osreg_pkg::DEV_ADDR) check({15'h0000, ak}, 16'h0000);
		end
	endtask
	// Write ends in stop, then no bus traffic while storing
	task automatic wr(input logic [6:0] adr, input logic [7:0] q[$]);
		hdr(adr, q);
		ctl.stop();
		repeat (20) @(negedge ref_clk_in);
	endtask
	// Command, repeated start, two bytes acked, CRC nacked, stop
	task automatic rd(input logic [15:0] cmd);
		hdr(osreg_pkg::DEV_ADDR, '{cmd[15:8], cmd[7:0]});
		ctl.start();
		ctl.xfer({osreg_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, ak);
		ctl.xfer(8'hFF, 1'b0, w[15:8], ak);
		ctl.xfer(8'hFF, 1'b0, w[7:0], ak);
		ctl.xfer(8'hFF, 1'b1, c, ak);
		ctl.stop();
		check({8'h00, c}, {8'h00, crc8(w)});
	endtask
	task automatic clr();
		wr(osreg_pkg::DEV_ADDR, '{8'h30, 8'h41});
	endtask
	// One raw result in, corrected result one clock later
	task automatic measure(input logic [15:0] t, h, et, eh);
		@(negedge ref_clk_in);
		raw_temp_in = t;
		raw_rh_in = h;
		meas_valid_in = 1'b1;
		@(negedge ref_clk_in);
		meas_valid_in = 1'b0;
		check({15'h0000, res_valid}, 16'h0001);
		check(temp_adj, et);
		check(rh_adj, eh);
	endtask
	task automatic sc_reset();
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'h8010);
		rd(osreg_pkg::CMD_OFFSET);
		check(w, 16'h0000);
		check({8'h00, c}, 16'h0081);
	endtask
	task automatic sc_flags();
		clr();
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'h0000);
		heater_on_in = 1'b1;
		track = 2'h3;
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'hAC00);
		heater_on_in = 1'b0;
		track = 2'h0;
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'h0000);
		// Each event alone; reset events leave the alert summary unjudged
		for (int i = 5; i >= 0; i--) begin
			@(negedge ref_clk_in);
			ev = 6'h01 << i;
			@(negedge ref_clk_in);
			ev = 6'h00;
			rd(osreg_pkg::CMD_STATUS);
			if (i > 1) check(w, 16'h8000 | (16'h0001 << (i + 4)));
			else check(w & 16'h7FFF, 16'h0010);
			clr();
		end
	endtask
	// Offset traffic only while no measurement runs
	task automatic sc_offset();
		wr(osreg_pkg::DEV_ADDR, '{8'hA0, 8'h04, 8'hAA, 8'h2A, crc8(16'hAA2A)});
		check(ofs_word, 16'hAA2A);
		rd(osreg_pkg::CMD_OFFSET);
		check(w, 16'hAA2A);
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'h0000);
		measure(16'h8000, 16'h4000, 16'h7580, 16'h5500);
		measure(16'h0500, 16'h0000, 16'h0000, 16'h1500);
		wr(osreg_pkg::DEV_ADDR, '{8'hA0, 8'h04, 8'h7F, 8'hFF, crc8(16'h7FFF)});
		measure(16'h1000, 16'h4000, 16'h2FC0, 16'h0080);
		measure(16'hF000, 16'h3000, 16'hFFFF, 16'h0000);
		wr(osreg_pkg::DEV_ADDR, '{8'hA0, 8'h04, 8'h12, 8'h34, crc8(16'h1234) ^ 8'h01});
		check(ofs_word, 16'h7FFF);
		wr(7'h45, '{8'h30, 8'h41});
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'h0001);
		clr();
		rd(osreg_pkg::CMD_STATUS);
		check(w, 16'h0000);
	endtask
	task automatic give_verdict();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge ref_clk_in);
		reset_in = 1'b0;
		repeat (5) @(negedge ref_clk_in);
		sc_reset();
		sc_flags();
		sc_offset();
		give_verdict();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk_in);
		err_total++;
		give_verdict();
	end
endmodule
bind osreg_top osreg_properties u_props (.ref_clk_in, .reset_in, .scl_in, .sda_in, .sda_out,
	.sda_oe_out, .meas_valid_in, .raw_temp_in, .raw_rh_in, .temp_adj_out, .rh_adj_out,
	.result_valid_out, .offset_word_out);
